// [include/srd_regs.svh]
// Opcode patterns and issue clock counts for the stack, rotate and string decoder
`ifndef SRD_REGS_SVH
`define SRD_REGS_SVH

// ---------------------------------------------------------------------------
// Opcode bytes and masks
// ---------------------------------------------------------------------------
`define SRD_OPC_GRP5          8'hFF
`define SRD_OPC_STORE_ALL     8'h60
`define SRD_OPC_STORE_FLAGS   8'h9C
`define SRD_OPC_MSR_READ      8'h32
`define SRD_OPC_TSC_READ      8'h31
`define SRD_OPC_REP           8'hF3
`define SRD_MASK_LSEG         8'hE7
`define SRD_PAT_LSEG          8'h06
`define SRD_MASK_XSEG         8'hC7
`define SRD_PAT_XSEG          8'h80
`define SRD_MASK_SHORT        8'hF8
`define SRD_PAT_SHORT         8'h50
`define SRD_MASK_IMM          8'hFD
`define SRD_PAT_IMM           8'h68
`define SRD_MASK_W            8'hFE
`define SRD_PAT_ROT_ONE       8'hD0
`define SRD_PAT_ROT_CL        8'hD2
`define SRD_PAT_ROT_IMM       8'hC0
`define SRD_PAT_PORT_IN       8'h6C
`define SRD_PAT_STR_LOAD      8'hAC

// ---------------------------------------------------------------------------
// ModRM fields
// ---------------------------------------------------------------------------
`define SRD_MODRM_REG_LSB     3
`define SRD_MODRM_MOD_LSB     6
`define SRD_MOD_REGISTER      2'h3
`define SRD_REG_PUSH          3'h6
`define SRD_REG_RCL           3'h2
`define SRD_REG_RCR           3'h3

// ---------------------------------------------------------------------------
// Clock counts
// ---------------------------------------------------------------------------
`define SRD_CLK_ONE           19'h00001
`define SRD_CLK_PUSH_MEM      19'h00003
`define SRD_CLK_STORE_ALL     19'h0000B
`define SRD_CLK_STORE_FLAGS   19'h00002
`define SRD_CLK_RCL_ONE       19'h00003
`define SRD_CLK_RCR_ONE       19'h00004
`define SRD_CLK_ROT_MULTI     19'h00008
`define SRD_CLK_MSR_READ      19'h00001
`define SRD_CLK_TSC_READ      19'h00001
`define SRD_CLK_PORT_IN_BASE  19'h00011
`define SRD_CLK_PORT_IN_PRIV  19'h00020
`define SRD_CLK_STR_LOAD_BASE 19'h00009

`endif

// [include/srd_pkg.sv]
// Types shared by the stack, rotate and string decoder
package srd_pkg;

  typedef enum logic [3:0] {
    SRD_OP_NONE        = 4'h0,
    SRD_OP_PUSH_RM     = 4'h1,
    SRD_OP_PUSH_SHORT  = 4'h2,
    SRD_OP_PUSH_LSEG   = 4'h3,
    SRD_OP_PUSH_XSEG   = 4'h4,
    SRD_OP_PUSH_IMM    = 4'h5,
    SRD_OP_STORE_ALL   = 4'h6,
    SRD_OP_STORE_FLAGS = 4'h7,
    SRD_OP_ROT_LEFT    = 4'h8,
    SRD_OP_ROT_RIGHT   = 4'h9,
    SRD_OP_MSR_READ    = 4'hA,
    SRD_OP_TSC_READ    = 4'hB,
    SRD_OP_PORT_IN     = 4'hC,
    SRD_OP_STR_LOAD    = 4'hD
  } srd_op_e;

  typedef enum logic [1:0] {
    SRD_ST_IDLE = 2'b01,
    SRD_ST_RUN  = 2'b10
  } srd_state_e;

  // One instruction as presented by the fetch stage
  typedef struct packed {
    logic        rep;        // F3 prefix seen
    logic        escape;     // 0F escape seen
    logic [7:0]  opcode;
    logic [7:0]  modrm;
    logic        prot_mode;  // Protected operation
    logic        priv_slow;  // Privilege check takes the long path
    logic [15:0] count;      // Iteration count register
  } srd_instr_s;

  // Decode result
  typedef struct packed {
    srd_op_e     op;
    logic        flags_kept;
    logic [18:0] cycles;
  } srd_dec_s;

  // Whole state of the decoder
  typedef struct packed {
    srd_state_e  state;
    logic [18:0] remain;
    srd_dec_s    dec;
    logic        done;
  } srd_state_s;

endpackage

// [rtl/srd_decoder.sv]
// Decoder and issue timer for stack stores, rotates through carry, reads and repeated strings
`include "srd_regs.svh"

module srd_decoder (
  input  wire logic               i_clock,
  input  wire logic               i_rst_n,
  input  wire logic               i_req,
  input  wire srd_pkg::srd_instr_s i_instr,
  output logic                    o_ready,
  output srd_pkg::srd_op_e        o_op,
  output logic                    o_flags_kept,
  output logic [18:0]             o_cycles,
  output logic                    o_done
);

  // -------------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------------

  // Matches a byte against a pattern under a mask
  function automatic logic srd_match(input logic [7:0] val, input logic [7:0] mask, input logic [7:0] pat);
    srd_match = (val & mask) == pat;
  endfunction

  // Classifies one instruction and works out its clock count
  function automatic srd_pkg::srd_dec_s srd_decode(input srd_pkg::srd_instr_s ins);
    srd_pkg::srd_dec_s d;
    logic [2:0]        reg_f;
    logic              is_reg;
    logic [18:0]       n4;
    logic [18:0]       n2;
    d      = '{op: srd_pkg::SRD_OP_NONE, flags_kept: 1'b0, cycles: `SRD_CLK_ONE};
    reg_f  = ins.modrm[`SRD_MODRM_REG_LSB +: 3];
    is_reg = ins.modrm[`SRD_MODRM_MOD_LSB +: 2] == `SRD_MOD_REGISTER;
    n4     = {1'b0, ins.count, 2'h0};
    n2     = {2'h0, ins.count, 1'b0};
    if (ins.escape) begin
      if (srd_match(ins.opcode, `SRD_MASK_XSEG, `SRD_PAT_XSEG)) begin
        d = '{op: srd_pkg::SRD_OP_PUSH_XSEG, flags_kept: 1'b1, cycles: `SRD_CLK_ONE};
      end else if (ins.opcode == `SRD_OPC_MSR_READ) begin
        d = '{op: srd_pkg::SRD_OP_MSR_READ, flags_kept: 1'b1, cycles: `SRD_CLK_MSR_READ};
      end else if (ins.opcode == `SRD_OPC_TSC_READ) begin
        d = '{op: srd_pkg::SRD_OP_TSC_READ, flags_kept: 1'b1, cycles: `SRD_CLK_TSC_READ};
      end
    end else if (ins.rep) begin
      if (srd_match(ins.opcode, `SRD_MASK_W, `SRD_PAT_PORT_IN)) begin
        d.op         = srd_pkg::SRD_OP_PORT_IN;
        d.flags_kept = 1'b1;
        d.cycles     = ((ins.prot_mode && ins.priv_slow) ? `SRD_CLK_PORT_IN_PRIV : `SRD_CLK_PORT_IN_BASE) + n4;
      end else if (srd_match(ins.opcode, `SRD_MASK_W, `SRD_PAT_STR_LOAD)) begin
        d.op         = srd_pkg::SRD_OP_STR_LOAD;
        d.flags_kept = 1'b1;
        d.cycles     = `SRD_CLK_STR_LOAD_BASE + n2;
      end
    end else if (ins.opcode == `SRD_OPC_GRP5 && reg_f == `SRD_REG_PUSH) begin
      d = '{op: srd_pkg::SRD_OP_PUSH_RM, flags_kept: 1'b1,
            cycles: is_reg ? `SRD_CLK_ONE : `SRD_CLK_PUSH_MEM};
    end else if (srd_match(ins.opcode, `SRD_MASK_SHORT, `SRD_PAT_SHORT)) begin
      d = '{op: srd_pkg::SRD_OP_PUSH_SHORT, flags_kept: 1'b1, cycles: `SRD_CLK_ONE};
    end else if (srd_match(ins.opcode, `SRD_MASK_IMM, `SRD_PAT_IMM)) begin
      d = '{op: srd_pkg::SRD_OP_PUSH_IMM, flags_kept: 1'b1, cycles: `SRD_CLK_ONE};
    end else if (srd_match(ins.opcode, `SRD_MASK_LSEG, `SRD_PAT_LSEG)) begin
      d = '{op: srd_pkg::SRD_OP_PUSH_LSEG, flags_kept: 1'b1, cycles: `SRD_CLK_ONE};
    end else if (ins.opcode == `SRD_OPC_STORE_ALL) begin
      d = '{op: srd_pkg::SRD_OP_STORE_ALL, flags_kept: 1'b1, cycles: `SRD_CLK_STORE_ALL};
    end else if (ins.opcode == `SRD_OPC_STORE_FLAGS) begin
      d = '{op: srd_pkg::SRD_OP_STORE_FLAGS, flags_kept: 1'b1, cycles: `SRD_CLK_STORE_FLAGS};
    end else if (srd_match(ins.opcode, `SRD_MASK_W, `SRD_PAT_ROT_ONE) ||
                 srd_match(ins.opcode, `SRD_MASK_W, `SRD_PAT_ROT_CL) ||
                 srd_match(ins.opcode, `SRD_MASK_W, `SRD_PAT_ROT_IMM)) begin
      if (reg_f == `SRD_REG_RCL) begin
        d.op     = srd_pkg::SRD_OP_ROT_LEFT;
        d.cycles = srd_match(ins.opcode, `SRD_MASK_W, `SRD_PAT_ROT_ONE) ? `SRD_CLK_RCL_ONE : `SRD_CLK_ROT_MULTI;
      end else if (reg_f == `SRD_REG_RCR) begin
        d.op     = srd_pkg::SRD_OP_ROT_RIGHT;
        d.cycles = srd_match(ins.opcode, `SRD_MASK_W, `SRD_PAT_ROT_ONE) ? `SRD_CLK_RCR_ONE : `SRD_CLK_ROT_MULTI;
      end
    end
    srd_decode = d;
  endfunction

  // -------------------------------------------------------------------------
  // Issue timer
  // -------------------------------------------------------------------------
  srd_pkg::srd_state_s st;
  srd_pkg::srd_state_s next_st;
  logic                accept;

  assign accept  = i_req && o_ready;
  assign o_ready = st.state == srd_pkg::SRD_ST_IDLE;

  // Accepts in idle, then holds busy for the decoded clock count
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    case (st.state)
      srd_pkg::SRD_ST_IDLE: begin
        if (i_req) begin
          next_st.dec = srd_decode(i_instr);
          // A one-clock instruction ends at once, so the next one can issue right behind it
          if (next_st.dec.cycles == `SRD_CLK_ONE) begin
            next_st.done = 1'b1;
          end else begin
            // The accept cycle and the done cycle both count towards the clock total
            next_st.remain = next_st.dec.cycles - `SRD_CLK_ONE - `SRD_CLK_ONE;
            next_st.state  = srd_pkg::SRD_ST_RUN;
          end
        end
      end
      srd_pkg::SRD_ST_RUN: begin
        if (st.remain == 19'h00000) begin
          next_st.done  = 1'b1;
          next_st.state = srd_pkg::SRD_ST_IDLE;
        end else begin
          next_st.remain = st.remain - `SRD_CLK_ONE;
        end
      end
      default: begin
        next_st.state = srd_pkg::SRD_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{state: srd_pkg::SRD_ST_IDLE, remain: 19'h00000,
              dec: '{op: srd_pkg::SRD_OP_NONE, flags_kept: 1'b0, cycles: 19'h00000}, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_op         = st.dec.op;
  assign o_flags_kept = st.dec.flags_kept;
  assign o_cycles     = st.dec.cycles;
  assign o_done       = st.done;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  logic plain;
  assign plain = accept && !i_instr.escape && !i_instr.rep;

  AST_PUSH_MEM: assert property (plain && i_instr.opcode == 8'hFF && i_instr.modrm[5:3] == 3'h6
    && i_instr.modrm[7:6] != 2'h3 |=> o_op == srd_pkg::SRD_OP_PUSH_RM && o_cycles == 19'h00003 ##2 o_done)
    else $error("memory push not 3 clocks");
  AST_PUSH_LSEG: assert property (plain && (i_instr.opcode & 8'hE7) == 8'h06
    |=> o_op == srd_pkg::SRD_OP_PUSH_LSEG && o_done)
    else $error("legacy segment push not 1 clock");
  AST_PUSH_XSEG: assert property (accept && i_instr.escape && i_instr.opcode == 8'hA8
    |=> o_op == srd_pkg::SRD_OP_PUSH_XSEG && o_cycles == 19'h00001)
    else $error("extended segment push misdecoded");
  AST_STORE_ALL: assert property (plain && i_instr.opcode == 8'h60
    |=> (!o_done && !o_ready) [*8] ##1 (!o_done && !o_ready) [*2] ##1 o_done && o_flags_kept)
    else $error("store all not 11 clocks");
  AST_STORE_FLAGS: assert property (plain && i_instr.opcode == 8'h9C
    |=> !o_done ##1 o_done && o_op == srd_pkg::SRD_OP_STORE_FLAGS && o_flags_kept)
    else $error("store flags not 2 clocks");
  AST_RCL: assert property (plain && i_instr.modrm[5:3] == 3'h2 && (i_instr.opcode & 8'hFE) == 8'hD0
    |=> o_op == srd_pkg::SRD_OP_ROT_LEFT && o_cycles == 19'h00003)
    else $error("rotate left by one not 3 clocks");
  AST_RCR: assert property (plain && i_instr.modrm[5:3] == 3'h3 && (i_instr.opcode & 8'hFE) == 8'hD2
    |=> o_op == srd_pkg::SRD_OP_ROT_RIGHT && o_cycles == 19'h00008)
    else $error("rotate right by count not 8 clocks");
  AST_MSR: assert property (accept && i_instr.escape && i_instr.opcode == 8'h32
    |=> o_op == srd_pkg::SRD_OP_MSR_READ && o_flags_kept)
    else $error("model register read misdecoded");
  AST_TSC: assert property (accept && i_instr.escape && i_instr.opcode == 8'h31
    |=> o_op == srd_pkg::SRD_OP_TSC_READ && o_flags_kept)
    else $error("timestamp read misdecoded");
  AST_PORT_IN: assert property (accept && !i_instr.escape && i_instr.rep && i_instr.opcode == 8'h6C
    |=> o_cycles == ($past(i_instr.prot_mode) && $past(i_instr.priv_slow) ? 19'd32 : 19'd17)
        + {1'b0, $past(i_instr.count), 2'h0})
    else $error("port string input count wrong");
  AST_STR_LOAD: assert property (accept && !i_instr.escape && i_instr.rep && i_instr.opcode == 8'hAD
    && i_instr.count == 16'h0002 |=> o_cycles == 19'd13 ##12 o_done)
    else $error("string load not 9+2n clocks");

  // Forms and timing not covered above
  AST_PUSH_REG: assert property (plain && i_instr.opcode == 8'hFF && i_instr.modrm[5:3] == 3'h6
    && i_instr.modrm[7:6] == 2'h3 |=> o_op == srd_pkg::SRD_OP_PUSH_RM && o_cycles == 19'h00001 && o_done)
    else $error("register push not 1 clock");
  AST_PUSH_SHORT: assert property (plain && (i_instr.opcode & 8'hF8) == 8'h50
    |=> o_op == srd_pkg::SRD_OP_PUSH_SHORT && o_cycles == 19'h00001 && o_done && o_flags_kept)
    else $error("short push not 1 clock");
  AST_PUSH_IMM: assert property (plain && (i_instr.opcode & 8'hFD) == 8'h68
    |=> o_op == srd_pkg::SRD_OP_PUSH_IMM && o_cycles == 19'h00001 && o_done)
    else $error("immediate push not 1 clock");
  AST_RCL_MULTI: assert property (plain && i_instr.modrm[5:3] == 3'h2 && (i_instr.opcode & 8'hFE) == 8'hC0
    |=> o_op == srd_pkg::SRD_OP_ROT_LEFT && o_cycles == 19'h00008 && !o_flags_kept ##7 o_done)
    else $error("rotate left by immediate not 8 clocks");
  AST_RCR_ONE: assert property (plain && i_instr.modrm[5:3] == 3'h3 && (i_instr.opcode & 8'hFE) == 8'hD0
    |=> o_op == srd_pkg::SRD_OP_ROT_RIGHT && o_cycles == 19'h00004 ##3 o_done)
    else $error("rotate right by one not 4 clocks");
  AST_PORT_IN_REAL: assert property (accept && !i_instr.escape && i_instr.rep && (i_instr.opcode & 8'hFE) == 8'h6C
    && !i_instr.prot_mode && i_instr.count == 16'h0005 |=> o_cycles == 19'h00025 && o_flags_kept ##36 o_done)
    else $error("port string input in real operation not 17+4n clocks");
  AST_DONE_READY: assert property (o_done |-> o_ready)
    else $error("done while still busy");
  AST_HOLD_BUSY: assert property (!o_ready |=> $stable(o_op) && $stable(o_cycles))
    else $error("decode changed while busy");

  COV_PUSH_MEM: cover property (accept && i_instr.opcode == 8'hFF ##3 o_done);
  COV_PORT_IN_SLOW: cover property (accept && i_instr.rep && i_instr.prot_mode && i_instr.priv_slow);
  COV_BACK_TO_BACK: cover property (o_done && accept);
  COV_STORE_ALL_PROT: cover property (accept && i_instr.opcode == 8'h60 && i_instr.prot_mode);
  COV_STR_LOAD_LONG: cover property (accept && i_instr.rep && i_instr.opcode == 8'hAD ##1 o_cycles > 19'h00100);

endmodule

// [bench/test_srd_decoder.sv]
// Self-checking bench for the stack, rotate and string decoder
module test_srd_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------
  // Signals and design
  // ------------------------------
  typedef struct {
    srd_pkg::srd_instr_s ins;
    srd_pkg::srd_op_e    op;
    logic [18:0]         cyc;
    logic                kept;
  } srd_item_s;

  logic                i_clock;
  logic                i_rst_n;
  logic                i_req;
  srd_pkg::srd_instr_s i_instr;
  logic                o_ready;
  srd_pkg::srd_op_e    o_op;
  logic                o_flags_kept;
  logic [18:0]         o_cycles;
  logic                o_done;
  int                  error_cnt;
  int                  compares;
  srd_item_s           q[$];

  srd_decoder i_srd_decoder (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_req        (i_req),
    .i_instr      (i_instr),
    .o_ready      (o_ready),
    .o_op         (o_op),
    .o_flags_kept (o_flags_kept),
    .o_cycles     (o_cycles),
    .o_done       (o_done)
  );

  // Core clock, 8 ns period
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  // ------------------------------
  // Compare, report and drive
  // ------------------------------
  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
    end
  endtask

  task automatic chk_val(input string name, input logic [18:0] exp, input logic [18:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("error_cnt %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Outputs expected while reset holds and right after release
  task automatic test_reset();
    chk_bit("ready", 1'b1, o_ready);
    chk_val("op", 19'h00000, 19'(o_op));
    chk_val("cycles", 19'h00000, o_cycles);
    chk_bit("flags_kept", 1'b0, o_flags_kept);
    chk_bit("done", 1'b0, o_done);
  endtask

  // Queues one instruction; pre is {rep, escape}, mode is {prot_mode, priv_slow}
  task automatic add(input logic [1:0] pre, input logic [7:0] opc, input logic [7:0] modrm, input logic [1:0] mode,
                     input logic [15:0] cnt, input srd_pkg::srd_op_e op, input int cyc, input logic kept);
    srd_item_s it;
    it.ins  = {pre, opc, modrm, mode, cnt};
    it.op   = op;
    it.cyc  = 19'(cyc);
    it.kept = kept;
    q.push_back(it);
  endtask

  // Streams the queue back to back; the next request is held while busy and must be ignored until done
  task automatic play();
    srd_item_s it;
    int        t;
    @(posedge i_clock);
    i_req   <= 1'b1;
    i_instr <= q[0].ins;
    @(negedge i_clock);
    while (q.size() != 0) begin
      it = q.pop_front();
      for (t = 0; t < 50 && o_ready !== 1'b1; t++) begin
        @(negedge i_clock);
      end
      if (t >= 50) begin
        chk_bit("ready wait", 1'b1, o_ready);
        summarize();
      end
      @(posedge i_clock);
      if (q.size() != 0) begin
        i_instr <= q[0].ins;
      end else begin
        i_req <= 1'b0;
      end
      for (t = 1; t <= 3000; t++) begin
        @(negedge i_clock);
        if (t == 1) begin
          chk_val("op", 19'(it.op), 19'(o_op));
          chk_val("cycles", it.cyc, o_cycles);
          chk_bit("flags_kept", it.kept, o_flags_kept);
        end
        chk_bit("ready", t == it.cyc, o_ready);
        chk_bit("done", t == it.cyc, o_done);
        if (t >= it.cyc || o_done === 1'b1) break;
      end
    end
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic test_push();
    add(2'h0, 8'hFF, 8'hF0, 2'h0, 16'h0000, srd_pkg::SRD_OP_PUSH_RM, 1, 1'b1);
    add(2'h0, 8'hFF, 8'h75, 2'h2, 16'h0000, srd_pkg::SRD_OP_PUSH_RM, 3, 1'b1);
    add(2'h0, 8'h50, 8'h00, 2'h0, 16'h0000, srd_pkg::SRD_OP_PUSH_SHORT, 1, 1'b1);
    add(2'h0, 8'h57, 8'h00, 2'h0, 16'h0000, srd_pkg::SRD_OP_PUSH_SHORT, 1, 1'b1);
    add(2'h0, 8'h68, 8'h00, 2'h0, 16'h0000, srd_pkg::SRD_OP_PUSH_IMM, 1, 1'b1);
    add(2'h0, 8'h6A, 8'h00, 2'h0, 16'h0000, srd_pkg::SRD_OP_PUSH_IMM, 1, 1'b1);
    play();
  endtask

  task automatic test_seg();
    for (int i = 0; i < 4; i++) begin
      add(2'h0, 8'(8'h06 + 8 * i), 8'h00, {i[0], 1'b0}, 16'h0000, srd_pkg::SRD_OP_PUSH_LSEG, 1, 1'b1);
    end
    add(2'h1, 8'hA0, 8'h00, 2'h0, 16'h0000, srd_pkg::SRD_OP_PUSH_XSEG, 1, 1'b1);
    add(2'h1, 8'hA8, 8'h00, 2'h2, 16'h0000, srd_pkg::SRD_OP_PUSH_XSEG, 1, 1'b1);
    play();
  endtask

  task automatic test_store();
    add(2'h0, 8'h60, 8'h00, 2'h0, 16'h0000, srd_pkg::SRD_OP_STORE_ALL, 11, 1'b1);
    add(2'h0, 8'h60, 8'h00, 2'h2, 16'h0000, srd_pkg::SRD_OP_STORE_ALL, 11, 1'b1);
    add(2'h0, 8'h9C, 8'h00, 2'h0, 16'h0000, srd_pkg::SRD_OP_STORE_FLAGS, 2, 1'b1);
    add(2'h0, 8'h9C, 8'h00, 2'h2, 16'h0000, srd_pkg::SRD_OP_STORE_FLAGS, 2, 1'b1);
    play();
  endtask

  // By-one, by-count and by-immediate forms, both w values, both directions
  task automatic test_rotate();
    for (int i = 0; i < 6; i++) begin
      for (int r = 2; r < 4; r++) begin
        add(2'h0, 8'(i < 4 ? 8'hD0 + i : 8'hBC + i), 8'(8'hC1 | (r << 3)), 2'h0, 16'h0000,
            r == 2 ? srd_pkg::SRD_OP_ROT_LEFT : srd_pkg::SRD_OP_ROT_RIGHT,
            i >= 2 ? 8 : (r == 2 ? 3 : 4), 1'b0);
      end
    end
    play();
  endtask

  task automatic test_reads();
    add(2'h1, 8'h32, 8'h00, 2'h0, 16'h0000, srd_pkg::SRD_OP_MSR_READ, 1, 1'b1);
    add(2'h1, 8'h31, 8'h00, 2'h2, 16'h0000, srd_pkg::SRD_OP_TSC_READ, 1, 1'b1);
    add(2'h2, 8'h90, 8'h00, 2'h0, 16'h0000, srd_pkg::SRD_OP_NONE, 1, 1'b0);
    add(2'h0, 8'hD1, 8'hC0, 2'h0, 16'h0000, srd_pkg::SRD_OP_NONE, 1, 1'b0);
    play();
  endtask

  // Count changes right after each accept, so only the sampled count may matter
  task automatic test_strings();
    add(2'h2, 8'h6C, 8'h00, 2'h0, 16'h0000, srd_pkg::SRD_OP_PORT_IN, 17, 1'b1);
    add(2'h2, 8'h6D, 8'h00, 2'h1, 16'h0005, srd_pkg::SRD_OP_PORT_IN, 37, 1'b1);
    add(2'h2, 8'h6C, 8'h00, 2'h2, 16'h0003, srd_pkg::SRD_OP_PORT_IN, 29, 1'b1);
    add(2'h2, 8'h6D, 8'h00, 2'h3, 16'h0007, srd_pkg::SRD_OP_PORT_IN, 60, 1'b1);
    add(2'h2, 8'hAC, 8'h00, 2'h0, 16'h0000, srd_pkg::SRD_OP_STR_LOAD, 9, 1'b1);
    add(2'h2, 8'hAD, 8'h00, 2'h3, 16'h012C, srd_pkg::SRD_OP_STR_LOAD, 609, 1'b1);
    add(2'h2, 8'hAC, 8'h00, 2'h2, 16'h0001, srd_pkg::SRD_OP_STR_LOAD, 11, 1'b1);
    add(2'h2, 8'hAD, 8'h00, 2'h1, 16'h0002, srd_pkg::SRD_OP_STR_LOAD, 13, 1'b1);
    play();
  endtask

  // Reset for 12 cycles, scenarios, verdict
  initial begin
    error_cnt = 0;
    compares  = 0;
    i_rst_n   = 1'b0;
    i_req     = 1'b0;
    i_instr   = '0;
    repeat (11) @(posedge i_clock);
    @(negedge i_clock);
    test_reset();
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(negedge i_clock);
    test_reset();
    test_push();
    test_seg();
    test_store();
    test_rotate();
    test_reads();
    test_strings();
    summarize();
  end
endmodule
